// *** src/cfa_access_ctrl.sv ***
// Card file access control: selection, condition checks, responses
`timescale 1ns/1ps
`default_nettype none
module cfa_access_ctrl
   import cfa_pkg::*;
#(
   parameter int unsigned NREC_W = 8
)
(
   input wire logic clock_i,
   input wire logic arst_n_i,
   // Command from the terminal side, same clock domain
   input wire logic cmd_valid_i,
   input wire logic [3:0] cmd_code_i,
   input wire logic [15:0] cmd_fid_i,
   // Header of the addressed file, looked up outside
   input wire logic [1:0] file_struct_i,
   input wire logic [19:0] file_acc_i,
   input wire logic file_invalid_i,
   input wire logic [15:0] file_size_i,
   input wire logic [7:0] file_reclen_i,
   input wire logic [NREC_W-1:0] file_last_upd_i,
   input wire logic [15:0] dir_free_i,
   // Holder-code status from the verification logic
   input wire logic code1_good_i,
   input wire logic code1_unblock_i,
   input wire logic code1_disabled_i,
   input wire logic code1_blocked_i,
   input wire logic code2_good_i,
   input wire logic code2_unblock_i,
   input wire logic code2_blocked_i,
   input wire logic code2_init_i,
   input wire logic [14:0] adm_grant_i,
   // Authentication values
   input wire logic [127:0] random_challenge_i,
   input wire logic [127:0] secret_key_i,
   input wire logic [95:0] auth_result_i,
   // Answers
   output logic resp_valid_o,
   output logic resp_ok_o,
   output logic [1:0] resp_kind_o,
   output logic [15:0] resp_fid_o,
   output logic [15:0] resp_size_o,
   output logic [19:0] resp_acc_o,
   output logic resp_invalid_o,
   output logic [1:0] resp_struct_o,
   output logic [7:0] resp_reclen_o,
   output logic [3:0] resp_code_info_o,
   output logic resp_reserved_o,
   output logic resp_admin_id_o,
   output logic [15:0] cur_dir_o,
   output logic [15:0] cur_ef_o,
   output logic cur_ef_valid_o,
   output logic [NREC_W-1:0] rec_ptr_o,
   output logic rec_ptr_valid_o,
   output logic auth_start_o,
   output logic [255:0] auth_in_o,
   output logic [95:0] auth_out_o
);
`include "cfa_regs.svh"

   //////////////////////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops
   logic rst_s1_q;
   logic rst_s2_q;
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   wire logic rst_n;
   assign rst_n = rst_s2_q;

   //////////////////////////////////////////////////////////////////////////////////////////
   // Session holder-code flags; card reset clears them
   logic c1_sat_q;
   logic c2_sat_q;
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         c1_sat_q <= 1'b0;
         c2_sat_q <= 1'b0;
      end else begin
         // Blocking wins: rights lapse the moment the code blocks
         c1_sat_q <= !code1_blocked_i && (c1_sat_q | code1_good_i | code1_unblock_i);
         c2_sat_q <= !code2_blocked_i && (c2_sat_q | code2_good_i | code2_unblock_i);
      end
   end
   // Flags are global, not per directory, so every directory sees them
   wire logic code1_ok;
   wire logic code2_ok;
   assign code1_ok = (c1_sat_q | code1_disabled_i) && !code1_blocked_i;
   assign code2_ok = c2_sat_q && !code2_blocked_i && code2_init_i;

   //////////////////////////////////////////////////////////////////////////////////////////
   // Command and file decoding
   cfa_cmd_type cmd;
   assign cmd = cfa_cmd_type'(cmd_code_i);
   wire logic [7:0] fid_hi;
   wire logic [7:0] fid_lo;
   assign fid_hi = cmd_fid_i[15:8];
   assign fid_lo = cmd_fid_i[7:0];
   cfa_kind_type sel_kind;
   assign sel_kind = (fid_hi == `CFA_ID_ROOT) ? CFA_K_ROOT :
      (fid_hi == `CFA_ID_DIR) ? CFA_K_DIR :
      ((fid_hi == `CFA_ID_EF_ROOT) || (fid_hi == `CFA_ID_EF_DIR)) ? CFA_K_EF :
      CFA_K_BAD;
   wire logic [7:0] dir_lo;
   assign dir_lo = cur_dir_o[7:0];
   // Reserved identifier classification
   wire logic dir_adm;
   wire logic dir_op;
   assign dir_adm = (fid_lo[7:4] == `CFA_NIB_ADM);
   assign dir_op = (fid_lo == `CFA_DIR_TEL) || (fid_lo[7:4] == `CFA_NIB_OP2);
   wire logic in_adm_dir;
   wire logic in_ops_dir;
   wire logic in_root;
   assign in_adm_dir = (dir_lo[7:4] == `CFA_NIB_ADM);
   assign in_ops_dir = (dir_lo == `CFA_DIR_TEL) || (dir_lo[7:4] == `CFA_NIB_OP2);
   assign in_root = (cur_dir_o == `CFA_ID_ROOT_FULL);
   wire logic ef_adm;
   wire logic ef_op;
   assign ef_adm = ((fid_hi == `CFA_ID_EF_DIR) && in_adm_dir) ||
      ((fid_hi == `CFA_ID_EF_DIR) && (fid_lo[7:4] == `CFA_NIB_OP1) &&
      ((dir_lo == `CFA_DIR_TEL) || (dir_lo == `CFA_DIR_NET) || (dir_lo == `CFA_DIR_ALT))) ||
      ((fid_hi == `CFA_ID_EF_ROOT) && in_root &&
      ((fid_lo == `CFA_EF_ADM1) || (fid_lo[7:4] == `CFA_NIB_ADME)));
   assign ef_op = ((fid_hi == `CFA_ID_EF_DIR) && in_ops_dir &&
      (fid_lo[7:4] >= `CFA_NIB_OP2) && (fid_lo[7:4] <= `CFA_NIB_ADM)) ||
      ((fid_hi == `CFA_ID_EF_ROOT) && in_root && (fid_lo[7:4] == `CFA_NIB_OP1));
   wire logic sel_adm;
   wire logic sel_rsv;
   assign sel_adm = (sel_kind == CFA_K_DIR) ? dir_adm : ef_adm;
   assign sel_rsv = (sel_kind == CFA_K_DIR) ? (dir_adm | dir_op) : (ef_adm | ef_op);

   //////////////////////////////////////////////////////////////////////////////////////////
   // Structure check and condition-nibble choice for commands on the current file
   cfa_struct_type st;
   assign st = cfa_struct_type'(file_struct_i);
   wire logic is_tr;
   wire logic is_lf;
   wire logic is_cy;
   assign is_tr = (st == CFA_ST_TRANSPARENT);
   assign is_lf = (st == CFA_ST_LINEAR);
   assign is_cy = (st == CFA_ST_CYCLIC);
   logic struct_ok;
   logic [2:0] cls;
   always_comb begin
      struct_ok = 1'b0;
      cls = `CFA_CLS_READ;
      case (cmd)
         CFA_CMD_READ_BIN: begin
            struct_ok = is_tr;
            cls = `CFA_CLS_READ;
         end
         CFA_CMD_UPD_BIN: begin
            struct_ok = is_tr;
            cls = `CFA_CLS_UPD;
         end
         CFA_CMD_READ_REC: begin
            struct_ok = is_lf | is_cy;
            cls = `CFA_CLS_READ;
         end
         CFA_CMD_UPD_REC: begin
            struct_ok = is_lf | is_cy;
            cls = `CFA_CLS_UPD;
         end
         CFA_CMD_SEEK: begin
            struct_ok = is_lf;
            cls = `CFA_CLS_READ;
         end
         CFA_CMD_INCREASE: begin
            struct_ok = is_cy;
            cls = `CFA_CLS_INC;
         end
         CFA_CMD_INVALIDATE: begin
            struct_ok = 1'b1;
            cls = `CFA_CLS_INV;
         end
         CFA_CMD_REHAB: begin
            struct_ok = 1'b1;
            cls = `CFA_CLS_REH;
         end
         default: begin
            struct_ok = 1'b0;
            cls = `CFA_CLS_READ;
         end
      endcase
   end
   // One nibble per class taken from the current file's header
   logic [3:0] nib [`CFA_NCLS];
   genvar gi;
   generate
      for (gi = 0; gi < `CFA_NCLS; gi++) begin : g_nib
         assign nib[gi] = file_acc_i[4*gi +: 4];
      end
   endgenerate

   cfa_cond_if cond_bus ();
   assign cond_bus.level = nib[cls];
   assign cond_bus.code1_ok = code1_ok;
   assign cond_bus.code2_ok = code2_ok;
   assign cond_bus.adm_map = adm_grant_i;
   cfa_level_eval u_eval (
      .cond(cond_bus.eval_mp)
   );

   //////////////////////////////////////////////////////////////////////////////////////////
   // Overall decision for the request
   wire logic is_file_cmd;
   wire logic is_code2_cmd;
   wire logic grant;
   assign is_file_cmd = (cmd >= CFA_CMD_READ_BIN) && (cmd <= CFA_CMD_REHAB);
   assign is_code2_cmd = ((cmd == CFA_CMD_CODE_VERIFY) || (cmd == CFA_CMD_CODE_UNBLOCK))
      && cmd_fid_i[0];
   // Directories have no current elementary file, hence no conditions to test
   assign grant = ((cmd == CFA_CMD_SELECT) && (sel_kind != CFA_K_BAD)) ||
      (cmd == CFA_CMD_STATUS) ||
      (is_file_cmd && cur_ef_valid_o && struct_ok && cond_bus.granted) ||
      (((cmd == CFA_CMD_CODE_VERIFY) || (cmd == CFA_CMD_CODE_UNBLOCK)) &&
      !(is_code2_cmd && !code2_init_i)) ||
      (cmd == CFA_CMD_AUTH);

   //////////////////////////////////////////////////////////////////////////////////////////
   // Selection state, record pointer and answer registers
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         cur_dir_o <= `CFA_ID_ROOT_FULL;
         cur_ef_o <= 16'h0000;
         cur_ef_valid_o <= 1'b0;
         rec_ptr_o <= '0;
         rec_ptr_valid_o <= 1'b0;
      end else if (cmd_valid_i && grant && (cmd == CFA_CMD_SELECT)) begin
         if (sel_kind == CFA_K_EF) begin
            cur_ef_o <= cmd_fid_i;
            cur_ef_valid_o <= 1'b1;
            rec_ptr_o <= is_cy ? file_last_upd_i : '0;
            rec_ptr_valid_o <= is_cy;
         end else begin
            cur_dir_o <= cmd_fid_i;
            cur_ef_valid_o <= 1'b0;
            rec_ptr_valid_o <= 1'b0;
         end
      end
   end

   // Answer fields registered one cycle after the request
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         resp_valid_o <= 1'b0;
         resp_ok_o <= 1'b0;
         resp_kind_o <= 2'h0;
         resp_fid_o <= 16'h0000;
         resp_size_o <= 16'h0000;
         resp_acc_o <= 20'h00000;
         resp_invalid_o <= 1'b0;
         resp_struct_o <= 2'h0;
         resp_reclen_o <= 8'h00;
         resp_code_info_o <= 4'h0;
         resp_reserved_o <= 1'b0;
         resp_admin_id_o <= 1'b0;
      end else begin
         resp_valid_o <= cmd_valid_i;
         resp_ok_o <= cmd_valid_i && grant;
         if (cmd_valid_i && grant && (cmd == CFA_CMD_SELECT) && (sel_kind == CFA_K_EF)) begin
            resp_kind_o <= `CFA_RESP_EF;
            resp_fid_o <= cmd_fid_i;
            resp_size_o <= file_size_i;
            resp_acc_o <= file_acc_i;
            resp_invalid_o <= file_invalid_i;
            resp_struct_o <= file_struct_i;
            resp_reclen_o <= is_tr ? 8'h00 : file_reclen_i;
            resp_reserved_o <= sel_rsv;
            resp_admin_id_o <= sel_adm;
         end else if (cmd_valid_i && grant &&
            ((cmd == CFA_CMD_SELECT) || (cmd == CFA_CMD_STATUS))) begin
            resp_kind_o <= `CFA_RESP_DIR;
            resp_fid_o <= (cmd == CFA_CMD_STATUS) ? cur_dir_o : cmd_fid_i;
            resp_size_o <= dir_free_i;
            resp_code_info_o <= {code2_init_i, code1_disabled_i, c1_sat_q, c2_sat_q};
            resp_reserved_o <= (cmd == CFA_CMD_SELECT) && sel_rsv;
            resp_admin_id_o <= (cmd == CFA_CMD_SELECT) && sel_adm;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // Authentication: challenge plus key out, 12-byte result back
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         auth_start_o <= 1'b0;
         auth_in_o <= '0;
         auth_out_o <= '0;
      end else begin
         auth_start_o <= cmd_valid_i && (cmd == CFA_CMD_AUTH);
         if (cmd_valid_i && (cmd == CFA_CMD_AUTH)) begin
            auth_in_o <= {random_challenge_i, secret_key_i};
         end
         auth_out_o <= auth_result_i;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // Checks
   a_never_refused: assert property (@(posedge clock_i) disable iff (!rst_n)
      (cmd_valid_i && is_file_cmd && nib[cls] == `CFA_LVL_NEVER) |=> !resp_ok_o)
      else $error("never level granted");
   a_rsvd_refused: assert property (@(posedge clock_i) disable iff (!rst_n)
      (cmd_valid_i && is_file_cmd && nib[cls] == `CFA_LVL_RSVD) |=> !resp_ok_o)
      else $error("reserved level granted");
   a_status_ok: assert property (@(posedge clock_i) disable iff (!rst_n)
      (cmd_valid_i && cmd == CFA_CMD_STATUS) |=> (resp_ok_o && resp_kind_o == `CFA_RESP_DIR))
      else $error("status refused");
   a_block_lose: assert property (@(posedge clock_i) disable iff (!rst_n)
      code1_blocked_i |=> !c1_sat_q)
      else $error("code one kept after block");
   a_c2_uninit: assert property (@(posedge clock_i) disable iff (!rst_n)
      (cmd_valid_i && is_code2_cmd && !code2_init_i) |=> !resp_ok_o)
      else $error("uninitialised code two accepted");
   a_status_keeps_ef: assert property (@(posedge clock_i) disable iff (!rst_n)
      (cmd_valid_i && cmd == CFA_CMD_STATUS) |=> $stable(cur_ef_o) && $stable(cur_ef_valid_o))
      else $error("status changed current file");
   a_lin_undef: assert property (@(posedge clock_i) disable iff (!rst_n)
      (cmd_valid_i && cmd == CFA_CMD_SELECT && sel_kind == CFA_K_EF && is_lf)
      |=> !rec_ptr_valid_o)
      else $error("linear pointer left defined");
   a_seek_lin: assert property (@(posedge clock_i) disable iff (!rst_n)
      (cmd_valid_i && cmd == CFA_CMD_SEEK && !is_lf) |=> !resp_ok_o)
      else $error("search on non-linear file");
endmodule
`default_nettype wire

// *** src/cfa_cond_if.sv ***
// Interface carrying access-condition queries between the checker and its evaluator
`timescale 1ns/1ps
`default_nettype none
interface cfa_cond_if;
   logic [3:0] level;
   logic code1_ok;
   logic code2_ok;
   logic [14:0] adm_map;
   logic granted;
   modport checker_mp (output level, output code1_ok, output code2_ok, output adm_map,
      input granted);
   modport eval_mp (input level, input code1_ok, input code2_ok, input adm_map,
      output granted);
endinterface
`default_nettype wire

// *** src/cfa_level_eval.sv ***
// Access-condition level evaluator: one nibble in, grant out
`timescale 1ns/1ps
`default_nettype none
module cfa_level_eval
   import cfa_pkg::*;
(
   cfa_cond_if.eval_mp cond
);
`include "cfa_regs.svh"
   wire logic is_always;
   wire logic is_c1;
   wire logic is_c2;
   wire logic is_adm;
   // Each level stands alone; passing code two never opens a code one gate
   assign is_always = (cond.level == `CFA_LVL_ALWAYS);
   assign is_c1 = (cond.level == `CFA_LVL_CODE1) && cond.code1_ok;
   assign is_c2 = (cond.level == `CFA_LVL_CODE2) && cond.code2_ok;
   // Administrative levels follow a per-level grant set by the issuer
   assign is_adm = (cond.level >= `CFA_LVL_ADM_LO) && (cond.level <= `CFA_LVL_ADM_HI)
      && cond.adm_map[cond.level];
   // Reserved and never levels fall through to refusal
   assign cond.granted = is_always | is_c1 | is_c2 | is_adm;
endmodule
`default_nettype wire

// *** src/cfa_pkg.sv ***
// Types shared by the card file access control block
package cfa_pkg;
   typedef enum logic [3:0] {
      CFA_CMD_SELECT = 4'h0,
      CFA_CMD_STATUS = 4'h1,
      CFA_CMD_READ_BIN = 4'h2,
      CFA_CMD_UPD_BIN = 4'h3,
      CFA_CMD_READ_REC = 4'h4,
      CFA_CMD_UPD_REC = 4'h5,
      CFA_CMD_SEEK = 4'h6,
      CFA_CMD_INCREASE = 4'h7,
      CFA_CMD_INVALIDATE = 4'h8,
      CFA_CMD_REHAB = 4'h9,
      CFA_CMD_CODE_VERIFY = 4'hA,
      CFA_CMD_CODE_UNBLOCK = 4'hB,
      CFA_CMD_AUTH = 4'hC
   } cfa_cmd_type;
   typedef enum logic [1:0] {
      CFA_ST_TRANSPARENT = 2'h0,
      CFA_ST_LINEAR = 2'h1,
      CFA_ST_CYCLIC = 2'h3
   } cfa_struct_type;
   typedef enum logic [1:0] {
      CFA_K_ROOT = 2'h0,
      CFA_K_DIR = 2'h1,
      CFA_K_EF = 2'h2,
      CFA_K_BAD = 2'h3
   } cfa_kind_type;
   typedef enum logic [1:0] {
      CFA_FSM_IDLE = 2'h0,
      CFA_FSM_CHECK = 2'h1,
      CFA_FSM_ANSWER = 2'h2
   } cfa_fsm_type;
endpackage

// *** src/cfa_regs.svh ***
// Constants for the card file access control block
`ifndef CFA_REGS_SVH
`define CFA_REGS_SVH
`define CFA_LVL_ALWAYS 4'h0
`define CFA_LVL_CODE1 4'h1
`define CFA_LVL_CODE2 4'h2
`define CFA_LVL_RSVD 4'h3
`define CFA_LVL_ADM_LO 4'h4
`define CFA_LVL_ADM_HI 4'hE
`define CFA_LVL_NEVER 4'hF
`define CFA_ID_ROOT 8'h3F
`define CFA_ID_DIR 8'h7F
`define CFA_ID_EF_ROOT 8'h2F
`define CFA_ID_EF_DIR 8'h6F
`define CFA_ID_ROOT_FULL 16'h3F00
`define CFA_DIR_NET 8'h20
`define CFA_DIR_TEL 8'h10
`define CFA_DIR_ALT 8'h21
`define CFA_NIB_ADM 4'h4
`define CFA_NIB_OP2 4'h2
`define CFA_NIB_OP1 4'h1
`define CFA_EF_ADM1 8'h01
`define CFA_NIB_ADME 4'hE
`define CFA_RANDOM_CHALLENGE_BITS 128
`define CFA_KEY_BITS 128
`define CFA_SIGNED_RESPONSE_BITS 32
`define CFA_CK_BITS 64
`define CFA_RESP_BYTES 12
`define CFA_CMD_W 4
`define CFA_RP_UNDEF 8'h00
`define CFA_RESP_DIR 2'h1
`define CFA_RESP_EF 2'h2
`define CFA_NCLS 5
`define CFA_CLS_READ 3'h0
`define CFA_CLS_UPD 3'h1
`define CFA_CLS_INC 3'h2
`define CFA_CLS_INV 3'h3
`define CFA_CLS_REH 3'h4
`endif

// *** verif/cfa_access_ctrl_tb_top.sv ***
// Self-checking bench for the card file access control block
`timescale 1ns/1ps
`default_nettype none
module cfa_access_ctrl_tb_top
   import cfa_pkg::*;
;
`include "cfa_regs.svh"
   logic clock = 1'h0;
   logic arst_n = 1'h0;
   logic cmd_valid;
   logic [3:0] cmd_code;
   logic [15:0] cmd_fid;
   logic [127:0] chal;
   logic [1:0] fstruct = 2'h0;
   logic [19:0] facc = 20'h00000;
   logic finv = 1'h0;
   logic [15:0] fsize = 16'h0000;
   logic [7:0] freclen = 8'h00;
   logic [7:0] flast = 8'h00;
   logic c1_good = 1'h0, c1_unb = 1'h0, c1_dis = 1'h0, c1_blk = 1'h0;
   logic c2_good = 1'h0, c2_unb = 1'h0, c2_blk = 1'h0, c2_init = 1'h1;
   logic [14:0] level_administrative = 15'h5550;
   logic [127:0] skey = 128'h5A5A3C3C0F0F9696A5A5C3C3F0F06969;
   logic [95:0] ares = 96'h00000000000000000000FFFF;
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;
   // Outputs are read through the instance, so the port list leaves them open
   cfa_access_ctrl #(.NREC_W(8)) dut (
      .clock_i(clock), .arst_n_i(arst_n), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
      .cmd_fid_i(cmd_fid), .file_struct_i(fstruct), .file_acc_i(facc), .file_invalid_i(finv),
      .file_size_i(fsize), .file_reclen_i(freclen), .file_last_upd_i(flast),
      .dir_free_i(16'h1234), .code1_good_i(c1_good), .code1_unblock_i(c1_unb),
      .code1_disabled_i(c1_dis), .code1_blocked_i(c1_blk), .code2_good_i(c2_good),
      .code2_unblock_i(c2_unb), .code2_blocked_i(c2_blk), .code2_init_i(c2_init),
      .adm_grant_i(level_administrative), .random_challenge_i(chal), .secret_key_i(skey), .auth_result_i(ares),
      .resp_valid_o(), .resp_ok_o(), .resp_kind_o(), .resp_fid_o(), .resp_size_o(),
      .resp_acc_o(), .resp_invalid_o(), .resp_struct_o(), .resp_reclen_o(),
      .resp_code_info_o(), .resp_reserved_o(), .resp_admin_id_o(), .cur_dir_o(),
      .cur_ef_o(), .cur_ef_valid_o(), .rec_ptr_o(), .rec_ptr_valid_o(),
      .auth_start_o(), .auth_in_o(), .auth_out_o());
   cfa_term_model term (.clock_i(clock), .resp_valid_i(dut.resp_valid_o),
      .resp_ok_i(dut.resp_ok_o), .code_info_i(dut.resp_code_info_o),
      .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .cmd_fid_o(cmd_fid), .chal_o(chal));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; the ceiling is far above the few hundred cycles needed
   initial begin
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         report_and_stop();
      end
   end
   // Shared helpers
   task automatic chk(input logic [255:0] got, input logic [255:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input cfa_cmd_type c, input logic ok, input logic [15:0] f = 16'h0000);
      logic v, o;
      term.issue(c, f, v, o);
      chk(v, 1'h1);
      chk(o, ok);
   endtask
   task automatic sel(input logic [1:0] s, input logic [19:0] a, input logic [15:0] f);
      fstruct = s;
      facc = a;
      cmd(CFA_CMD_SELECT, 1'h1, f);
   endtask
   // Success pulses, one cycle wide, order {code1 good, code1 unblock, code2 good, unblock}
   task automatic pulse(input logic [3:0] m);
      @(posedge clock);
      #1;
      {c1_good, c1_unb, c2_good, c2_unb} = m;
      @(posedge clock);
      #1;
      {c1_good, c1_unb, c2_good, c2_unb} = 4'h0;
   endtask
   task automatic do_reset();
      arst_n = 1'h0;
      repeat (16) @(posedge clock);
      #1;
      arst_n = 1'h1;
      repeat (2) @(posedge clock);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Directory and file selection answers, pointer setup and status
   task automatic t_select();
      cmd(CFA_CMD_SELECT, 1'h1, 16'h7F20);
      chk({dut.resp_kind_o, dut.resp_fid_o}, {`CFA_RESP_DIR, 16'h7F20});
      chk({dut.resp_code_info_o, dut.resp_admin_id_o}, {4'h8, 1'h0});
      chk(dut.resp_size_o, 16'h1234);
      chk(dut.resp_reserved_o, 1'h1);
      cmd(CFA_CMD_READ_BIN, 1'h0);
      cmd(CFA_CMD_SELECT, 1'h1, 16'h7F43);
      chk(dut.resp_admin_id_o, 1'h1);
      cmd(CFA_CMD_SELECT, 1'h0, 16'h5A00);
      finv = 1'h1;
      fsize = 16'h00B0;
      freclen = 8'h1C;
      sel(2'h1, 20'hFFFFF, 16'h6F3A);
      chk({dut.resp_kind_o, dut.resp_fid_o, dut.resp_size_o}, {`CFA_RESP_EF, 32'h6F3A00B0});
      chk({dut.resp_acc_o, dut.resp_invalid_o, dut.resp_struct_o}, {20'hFFFFF, 3'h5});
      chk({dut.resp_reclen_o, dut.rec_ptr_valid_o}, {8'h1C, 1'h0});
      finv = 1'h0;
      flast = 8'h05;
      sel(2'h3, 20'hFFFFF, 16'h6F3B);
      chk({dut.rec_ptr_valid_o, dut.rec_ptr_o}, {1'h1, 8'h05});
      cmd(CFA_CMD_STATUS, 1'h1);
      chk({dut.resp_kind_o, dut.resp_fid_o, dut.cur_ef_o}, {`CFA_RESP_DIR, 32'h7F436F3B});
   endtask
   // Every level code under two different administrative grant patterns
   task automatic t_levels();
      logic [14:0] pat[2] = '{15'h5550, 15'h2AB0};
      logic e;
      for (int p = 0; p < 2; p++) begin
         level_administrative = pat[p];
         for (int lv = 0; lv < 16; lv++) begin
            sel(2'h0, {16'hFFFF, 4'(lv)}, 16'h6F07);
            e = (lv == 0) || (lv >= 4 && lv <= 14 && pat[p][lv] === 1'h1);
            cmd(CFA_CMD_READ_BIN, e);
         end
      end
   endtask
   // Read needs code one, update needs code two
   task automatic t_codes();
      sel(2'h0, 20'hFFF21, 16'h6F07);
      cmd(CFA_CMD_READ_BIN, 1'h0);
      c1_dis = 1'h1;
      cmd(CFA_CMD_READ_BIN, 1'h1);
      c1_dis = 1'h0;
      pulse(4'h2);
      cmd(CFA_CMD_READ_BIN, 1'h0);
      cmd(CFA_CMD_UPD_BIN, 1'h1);
      c2_blk = 1'h1;
      cmd(CFA_CMD_UPD_BIN, 1'h0);
      c2_blk = 1'h0;
      pulse(4'h1);
      cmd(CFA_CMD_UPD_BIN, 1'h1);
      pulse(4'h8);
      cmd(CFA_CMD_SELECT, 1'h1, 16'h7F10);
      sel(2'h0, 20'hFFF21, 16'h6F07);
      chk({dut.resp_reserved_o, dut.resp_admin_id_o}, 2'h0);
      cmd(CFA_CMD_READ_BIN, 1'h1);
      c1_blk = 1'h1;
      cmd(CFA_CMD_READ_BIN, 1'h0);
      c1_blk = 1'h0;
      cmd(CFA_CMD_READ_BIN, 1'h0);
      pulse(4'h4);
      cmd(CFA_CMD_READ_BIN, 1'h1);
      c2_init = 1'h0;
      cmd(CFA_CMD_STATUS, 1'h1);
      chk({dut.resp_code_info_o, term.code2_avail_q}, {4'h3, 1'h0});
      cmd(CFA_CMD_CODE_VERIFY, 1'h0, 16'h0001);
      cmd(CFA_CMD_CODE_UNBLOCK, 1'h0, 16'h0001);
      c2_init = 1'h1;
      cmd(CFA_CMD_STATUS, 1'h1);
      chk({dut.resp_code_info_o, term.code2_avail_q}, {4'hB, 1'h1});
   endtask
   // Function table per structure; search shares the read condition
   task automatic t_struct();
      logic [1:0] st[3] = '{2'h0, 2'h1, 2'h3};
      logic [7:0] msk[3] = '{8'hC3, 8'hDC, 8'hEC};
      for (int s = 0; s < 3; s++) begin
         sel(st[s], 20'h00000, 16'h6F20);
         for (int c = 2; c < 10; c++) begin
            cmd(cfa_cmd_type'(c), msk[s][c - 2]);
         end
      end
      sel(2'h1, 20'h0000F, 16'h6F21);
      chk({dut.resp_reserved_o, dut.resp_admin_id_o}, 2'h2);
      cmd(CFA_CMD_SEEK, 1'h0);
      cmd(CFA_CMD_UPD_REC, 1'h1);
      sel(2'h1, 20'hFFFF0, 16'h6F21);
      cmd(CFA_CMD_SEEK, 1'h1);
   endtask
   // Challenge and key go out together; the 12-byte result follows its input
   task automatic t_auth();
      logic v, o;
      term.issue(CFA_CMD_AUTH, 16'h0000, v, o);
      chk({v, o, dut.auth_start_o}, 3'h7);
      chk(dut.auth_in_o, {chal, skey});
      ares = 96'h0F1E2D3C4B5A69788796A5B4;
      @(posedge clock);
      #1;
      chk({dut.auth_start_o, dut.auth_out_o}, {1'h0, 96'h0F1E2D3C4B5A69788796A5B4});
   endtask
   // A second reset starts a new session with no satisfied codes
   task automatic t_session();
      sel(2'h0, 20'h00001, 16'h6F07);
      cmd(CFA_CMD_READ_BIN, 1'h1);
      do_reset();
      chk(dut.cur_dir_o, 16'h3F00);
      sel(2'h0, 20'hFFFFF, 16'h3F00);
      cmd(CFA_CMD_READ_BIN, 1'h0);
      sel(2'h0, 20'h00001, 16'h2F01);
      chk(dut.resp_admin_id_o, 1'h1);
      cmd(CFA_CMD_READ_BIN, 1'h0);
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      do_reset();
      chk({dut.cur_dir_o, dut.cur_ef_valid_o}, {16'h3F00, 1'h0});
      t_select();
      t_levels();
      t_codes();
      t_struct();
      t_auth();
      t_session();
      report_and_stop();
   end
endmodule
`default_nettype wire

// *** verif/cfa_term_model.sv ***
// Terminal-side model that issues card commands one at a time
`timescale 1ns/1ps
`default_nettype none
module cfa_term_model
   import cfa_pkg::*;
(
   input wire logic clock_i,
   input wire logic resp_valid_i,
   input wire logic resp_ok_i,
   input wire logic [3:0] code_info_i,
   output logic cmd_valid_o,
   output logic [3:0] cmd_code_o,
   output logic [15:0] cmd_fid_o,
   output logic [127:0] chal_o
);
   logic code2_avail_q;
   // Idle lines, and the challenge handed to the card for authentication
   initial begin
      cmd_valid_o = 1'h0;
      cmd_code_o = 4'hF;
      cmd_fid_o = 16'hFFFF;
      chal_o = 128'h0123456789ABCDEFFEDCBA9876543210;
      code2_avail_q = 1'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One request per call; after it the lines show the inverse, never a stale copy
   task automatic issue(input cfa_cmd_type c, input logic [15:0] f, output logic vld,
      output logic ok);
      @(posedge clock_i);
      #1;
      cmd_valid_o = 1'h1;
      cmd_code_o = c;
      cmd_fid_o = f;
      @(posedge clock_i);
      #1;
      cmd_valid_o = 1'h0;
      cmd_code_o = ~c;
      cmd_fid_o = ~f;
      vld = resp_valid_i;
      ok = resp_ok_i;
      // Availability of code two is learnt only from a status answer
      if (c == CFA_CMD_STATUS && resp_valid_i === 1'h1) begin
         code2_avail_q = code_info_i[3];
      end
   endtask
endmodule
`default_nettype wire
